// ==== src/sticky_status.sv ====
`timescale 1ns/1ns
module sticky_status (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       resetn,
    // Events and clear.
    input  wire logic [7:0] detect,
    input  wire logic [7:0] clearMask,
    output logic      [7:0] status
);
    logic [7:0] next_status;

    always_comb begin
        next_status = (status & ~clearMask) | detect;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status <= wake_pkg::RESET_BYTE;
        end else begin
            status <= next_status;
        end
    end
endmodule

// ==== src/sync2.sv ====
`timescale 1ns/1ns
module sync2 #(
    parameter int W = 8
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         resetn,
    // Data.
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage1;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage1 <= '0;
            dout   <= '0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule

// ==== src/wake_pkg.sv ====
package wake_pkg;

    localparam logic [7:0] OFF_GP_STATUS   = 8'h01;
    localparam logic [7:0] OFF_WAKE_EN     = 8'h02;
    localparam logic [7:0] OFF_WAKE_EN_GP  = 8'h03;
    localparam logic [7:0] OFF_WAKE_CFG    = 8'h04;
    localparam logic [7:0] OFF_SMI_EN      = 8'h13;

    localparam logic [7:0] RESET_BYTE      = 8'h00;
    localparam logic [7:0] SMI_EN_MASK     = 8'h5f;
    localparam logic [7:0] CFG_MASK        = 8'h0f;

    localparam int         CFG_PULSE_BIT   = 3;
    localparam int         CFG_SWAP_BIT    = 2;
    localparam logic [1:0] BANK_EVENTS     = 2'h2;

    localparam int         PULSE_NS        = 100;
    localparam int         CLK_NS          = 10;
    localparam int         PULSE_CYCLES    = (PULSE_NS + CLK_NS - 1) / CLK_NS;

    typedef struct packed {
        logic [7:0] wakeEnablePrimary;
        logic [7:0] wakeEnableGpInputs;
        logic [7:0] wakeConfiguration;
        logic [7:0] smiRouteEnablePrimary;
        logic [7:0] readData;
    } regs_s;

    typedef struct packed {
        logic clockIn;
        logic dataIn;
    } ps_port_s;

endpackage

// ==== src/wakeup_event_routing.sv ====
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
module wakeup_event_routing (
    // Clock and reset.
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic                softReset,
    // Register port.
    input  wire logic [7:0]          address,
    input  wire logic [7:0]          writeData,
    input  wire logic                writeStrobe,
    input  wire logic                readStrobe,
    output logic      [7:0]          readData,
    // Detected primary events, sticky, bit order as the primary enable.
    input  wire logic [7:0]          primaryEventStatus,
    // Raw general-purpose event inputs, pulses from pins.
    input  wire logic [7:0]          generalPurposeEventInput,
    // Sleep state, power button request and keyboard/mouse pins.
    input  wire logic                inS3,
    input  wire logic                powerButtonRequest,
    input  wire wake_pkg::ps_port_s  keyboardPins,
    input  wire wake_pkg::ps_port_s  mousePins,
    // Outputs.
    output wake_pkg::ps_port_s       keyboardToController,
    output wake_pkg::ps_port_s       mouseToController,
    output logic      [1:0]          bankSelect,
    output logic                     powerButtonPulse,
    output logic                     powerWakeupRequestN,
    output logic                     systemMgmtInterruptN
);
    typedef struct packed {
        wake_pkg::regs_s    regs;
        wake_pkg::ps_port_s keyboard_event;
        wake_pkg::ps_port_s mouse;
        logic [3:0]         pulseCount;
        logic               pulse;
        logic               buttonSeen;
        logic               wakeN;
        logic               smiN;
    } state_s;

    state_s     st;
    state_s     next_st;
    logic [7:0] gpSync;
    logic [7:0] gpStatus;
    logic [7:0] gpClear;
    logic [7:0] primarySync;
    logic [5:0] pinSync;
    logic [5:0] pinRaw;
    logic       eventsBank;

    assign pinRaw = {keyboardPins, mousePins, inS3, powerButtonRequest};

    sync2 #(.W(8)) u_gp_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    (generalPurposeEventInput),
        .dout   (gpSync)
    );

    sync2 #(.W(8)) u_prim_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    (primaryEventStatus),
        .dout   (primarySync)
    );

    sync2 #(.W(6)) u_pin_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    (pinRaw),
        .dout   (pinSync)
    );

    assign eventsBank = (st.regs.wakeConfiguration[1:0] == wake_pkg::BANK_EVENTS);
    assign gpClear    = (writeStrobe && address == wake_pkg::OFF_GP_STATUS) ? writeData : 8'h00;

    sticky_status u_gp_status (
        .clk       (clk),
        .resetn    (resetn),
        .detect    (gpSync),
        .clearMask (gpClear),
        .status    (gpStatus)
    );

    always_comb begin
        next_st = st;
        next_st.regs.readData = wake_pkg::RESET_BYTE;
        if (writeStrobe) begin
            case (address)
                wake_pkg::OFF_WAKE_EN: begin
                    next_st.regs.wakeEnablePrimary = writeData;
                end
                wake_pkg::OFF_WAKE_EN_GP: begin
                    next_st.regs.wakeEnableGpInputs = writeData;
                end
                wake_pkg::OFF_WAKE_CFG: begin
                    next_st.regs.wakeConfiguration = writeData & wake_pkg::CFG_MASK;
                end
                wake_pkg::OFF_SMI_EN: begin
                    if (eventsBank) begin
                        next_st.regs.smiRouteEnablePrimary = writeData & wake_pkg::SMI_EN_MASK;
                    end
                end
                default: begin
                end
            endcase
        end
        if (readStrobe) begin
            case (address)
                wake_pkg::OFF_GP_STATUS: begin
                    next_st.regs.readData = gpStatus;
                end
                wake_pkg::OFF_WAKE_EN: begin
                    next_st.regs.readData = st.regs.wakeEnablePrimary;
                end
                wake_pkg::OFF_WAKE_EN_GP: begin
                    next_st.regs.readData = st.regs.wakeEnableGpInputs;
                end
                wake_pkg::OFF_WAKE_CFG: begin
                    next_st.regs.readData = st.regs.wakeConfiguration;
                end
                wake_pkg::OFF_SMI_EN: begin
                    if (eventsBank) begin
                        next_st.regs.readData = st.regs.smiRouteEnablePrimary;
                    end
                end
                default: begin
                end
            endcase
        end
        if (st.regs.wakeConfiguration[wake_pkg::CFG_SWAP_BIT]) begin
            next_st.keyboard_event   = pinSync[3:2];
            next_st.mouse = pinSync[5:4];
        end else begin
            next_st.keyboard_event   = pinSync[5:4];
            next_st.mouse = pinSync[3:2];
        end
        next_st.buttonSeen = pinSync[0];
        if (st.pulseCount != 4'h0) begin
            next_st.pulseCount = st.pulseCount - 4'h1;
        end else if (pinSync[0] && !st.buttonSeen && pinSync[1]
                     && st.regs.wakeConfiguration[wake_pkg::CFG_PULSE_BIT]) begin
            next_st.pulseCount = 4'(wake_pkg::PULSE_CYCLES);
        end
        next_st.pulse = (next_st.pulseCount != 4'h0);
        next_st.wakeN = ~(|(primarySync & st.regs.wakeEnablePrimary)
                          | |(gpStatus & st.regs.wakeEnableGpInputs));
        next_st.smiN  = ~|(primarySync & st.regs.smiRouteEnablePrimary
                           & wake_pkg::SMI_EN_MASK);
        if (softReset) begin
            next_st.regs.wakeEnablePrimary     = wake_pkg::RESET_BYTE;
            next_st.regs.wakeEnableGpInputs    = wake_pkg::RESET_BYTE;
            next_st.regs.wakeConfiguration     = wake_pkg::RESET_BYTE;
            next_st.regs.smiRouteEnablePrimary = wake_pkg::RESET_BYTE;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st       <= '0;
            st.wakeN <= 1'b1;
            st.smiN  <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign readData             = st.regs.readData;
    assign keyboardToController = st.keyboard_event;
    assign mouseToController    = st.mouse;
    assign bankSelect           = st.regs.wakeConfiguration[1:0];
    assign powerButtonPulse     = st.pulse;
    assign powerWakeupRequestN  = st.wakeN;
    assign systemMgmtInterruptN = st.smiN;

    a_reset_clears: assert property (@(posedge clk) disable iff (!resetn)
        softReset |=> (st.regs.wakeConfiguration == 8'h00 && st.regs.wakeEnablePrimary == 8'h00))
        else $error("soft reset did not clear registers");

    a_wake_request: assert property (@(posedge clk) disable iff (!resetn)
        (|(gpStatus & st.regs.wakeEnableGpInputs)) |=> !powerWakeupRequestN)
        else $error("wake request not asserted");

    a_enable_write: assert property (@(posedge clk) disable iff (!resetn)
        (writeStrobe && address == 8'h02 && !softReset) |=> st.regs.wakeEnablePrimary == $past(writeData))
        else $error("primary enable write lost");

    a_bank_gate: assert property (@(posedge clk) disable iff (!resetn)
        (writeStrobe && address == 8'h13 && !eventsBank && !softReset)
        |=> $stable(st.regs.smiRouteEnablePrimary))
        else $error("smi routing written outside bank 2");

    a_smi_reserved: assert property (@(posedge clk) disable iff (!resetn)
        (st.regs.smiRouteEnablePrimary & 8'ha0) == 8'h00)
        else $error("reserved smi bits set");

    a_smi_release: assert property (@(posedge clk) disable iff (!resetn)
        (~|(primarySync & st.regs.smiRouteEnablePrimary)) |=> systemMgmtInterruptN)
        else $error("smi held without cause");

    a_pulse_gate: assert property (@(posedge clk) disable iff (!resetn)
        (!st.regs.wakeConfiguration[3] && st.pulseCount == 4'h0) |=> !powerButtonPulse)
        else $error("pulse without enable");

    a_swap_path: assert property (@(posedge clk) disable iff (!resetn)
        (st.regs.wakeConfiguration[2] && $stable(st.regs.wakeConfiguration))
        |=> keyboardToController == $past(pinSync[3:2]))
        else $error("keyboard swap wrong");

    a_sticky_hold: assert property (@(posedge clk) disable iff (!resetn)
        (gpStatus[0] && !gpClear[0]) |=> gpStatus[0])
        else $error("status bit dropped");

    a_reset_rest: assert property (@(posedge clk) disable iff (!resetn)
        softReset
        |=> (st.regs.wakeEnableGpInputs == 8'h00 && st.regs.smiRouteEnablePrimary == 8'h00))
        else $error("soft reset left enables set");

    a_wake_primary: assert property (@(posedge clk) disable iff (!resetn)
        (|(primarySync & st.regs.wakeEnablePrimary))
        |=> !powerWakeupRequestN)
        else $error("wake request missing for primary event");

    a_wake_release: assert property (@(posedge clk) disable iff (!resetn)
        (~|(primarySync & st.regs.wakeEnablePrimary) && ~|(gpStatus & st.regs.wakeEnableGpInputs))
        |=> powerWakeupRequestN)
        else $error("wake request held without cause");

    a_gp_ring_wake: assert property (@(posedge clk) disable iff (!resetn)
        (gpStatus[4] && st.regs.wakeEnableGpInputs[4])
        |=> !powerWakeupRequestN)
        else $error("shared input four does not wake");

    a_gp_enable_write: assert property (@(posedge clk) disable iff (!resetn)
        (writeStrobe && address == 8'h03 && !softReset)
        |=> st.regs.wakeEnableGpInputs == $past(writeData))
        else $error("general-purpose enable write lost");

    a_cfg_write: assert property (@(posedge clk) disable iff (!resetn)
        (writeStrobe && address == 8'h04 && !softReset)
        |=> st.regs.wakeConfiguration == ($past(writeData) & 8'h0f))
        else $error("configuration write lost");

    a_read_primary: assert property (@(posedge clk) disable iff (!resetn)
        (readStrobe && address == 8'h02)
        |=> readData == $past(st.regs.wakeEnablePrimary))
        else $error("primary enable read wrong");

    a_read_gp_enable: assert property (@(posedge clk) disable iff (!resetn)
        (readStrobe && address == 8'h03)
        |=> readData == $past(st.regs.wakeEnableGpInputs))
        else $error("general-purpose enable read wrong");

    a_read_cfg: assert property (@(posedge clk) disable iff (!resetn)
        (readStrobe && address == 8'h04)
        |=> readData == $past(st.regs.wakeConfiguration))
        else $error("configuration read wrong");

    a_read_idle: assert property (@(posedge clk) disable iff (!resetn)
        !readStrobe
        |=> readData == 8'h00)
        else $error("read data outside its cycle");

    a_bank_output: assert property (@(posedge clk) disable iff (!resetn)
        (writeStrobe && address == 8'h04 && !softReset)
        |=> bankSelect == $past(writeData[1:0]))
        else $error("bank select does not follow configuration");

    a_smi_assert: assert property (@(posedge clk) disable iff (!resetn)
        (|(primarySync & st.regs.smiRouteEnablePrimary))
        |=> !systemMgmtInterruptN)
        else $error("smi missing for routed event");

    a_smi_software: assert property (@(posedge clk) disable iff (!resetn)
        (primarySync[6] && st.regs.smiRouteEnablePrimary[6])
        |=> !systemMgmtInterruptN)
        else $error("software event not routed to smi");

    a_smi_write: assert property (@(posedge clk) disable iff (!resetn)
        (writeStrobe && address == 8'h13 && eventsBank && !softReset)
        |=> st.regs.smiRouteEnablePrimary == ($past(writeData) & 8'h5f))
        else $error("smi routing write lost");

    a_smi_read: assert property (@(posedge clk) disable iff (!resetn)
        (readStrobe && address == 8'h13 && eventsBank)
        |=> readData == $past(st.regs.smiRouteEnablePrimary))
        else $error("smi routing read wrong");

    a_smi_hidden: assert property (@(posedge clk) disable iff (!resetn)
        (readStrobe && address == 8'h13 && !eventsBank)
        |=> readData == 8'h00)
        else $error("smi routing visible outside bank 2");

    a_status_read: assert property (@(posedge clk) disable iff (!resetn)
        (readStrobe && address == 8'h01)
        |=> readData == $past(gpStatus))
        else $error("status read wrong");

    a_status_set: assert property (@(posedge clk) disable iff (!resetn)
        (|gpSync)
        |=> ((gpStatus & $past(gpSync)) == $past(gpSync)))
        else $error("detected event not latched");

    a_status_clear: assert property (@(posedge clk) disable iff (!resetn)
        (gpClear[4] && !gpSync[4])
        |=> !gpStatus[4])
        else $error("status bit not cleared");

    a_swap_off: assert property (@(posedge clk) disable iff (!resetn)
        !st.regs.wakeConfiguration[2]
        |=> keyboardToController == $past(pinSync[5:4]))
        else $error("keyboard path swapped while disabled");

    a_swap_mouse: assert property (@(posedge clk) disable iff (!resetn)
        st.regs.wakeConfiguration[2]
        |=> mouseToController == $past(pinSync[5:4]))
        else $error("mouse swap wrong");

    a_pulse_start: assert property (@(posedge clk) disable iff (!resetn)
        (st.pulseCount == 4'h0 && pinSync[0] && !st.buttonSeen && pinSync[1] && st.regs.wakeConfiguration[3])
        |=> powerButtonPulse)
        else $error("pulse not started");

    a_pulse_sleep: assert property (@(posedge clk) disable iff (!resetn)
        (!pinSync[1] && st.pulseCount == 4'h0)
        |=> !powerButtonPulse)
        else $error("pulse outside sleep state");

    a_pulse_end: assert property (@(posedge clk) disable iff (!resetn)
        (st.pulseCount == 4'h1)
        |=> !powerButtonPulse)
        else $error("pulse too long");

    a_pulse_hold: assert property (@(posedge clk) disable iff (!resetn)
        (st.pulseCount > 4'h1)
        |=> powerButtonPulse)
        else $error("pulse too short");
endmodule

// ==== testbench/wakeup_event_routing_tb_top.sv ====
`timescale 1ns/1ns
`define CHK(got, exp) begin nTests++; if ((got) !== (exp)) begin nErrors++; $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module wakeup_event_routing_tb_top;
    logic               clk;
    logic               resetn;
    logic               softReset;
    logic [7:0]         address;
    logic [7:0]         writeData;
    logic               writeStrobe;
    logic               readStrobe;
    logic [7:0]         readData;
    logic [7:0]         primaryEventStatus;
    logic [7:0]         generalPurposeEventInput;
    logic               inS3;
    logic               powerButtonRequest;
    wake_pkg::ps_port_s keyboardPins;
    wake_pkg::ps_port_s mousePins;
    wake_pkg::ps_port_s keyboardToController;
    wake_pkg::ps_port_s mouseToController;
    logic [1:0]         bankSelect;
    logic               powerButtonPulse;
    logic               powerWakeupRequestN;
    logic               systemMgmtInterruptN;
    int                 nErrors = 0;
    int                 nTests = 0;
    logic [7:0]         d;
    int                 c;

    wakeup_event_routing i_dut (.clk(clk), .resetn(resetn), .softReset(softReset),
        .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
        .readStrobe(readStrobe), .readData(readData), .primaryEventStatus(primaryEventStatus),
        .generalPurposeEventInput(generalPurposeEventInput), .inS3(inS3),
        .powerButtonRequest(powerButtonRequest), .keyboardPins(keyboardPins),
        .mousePins(mousePins), .keyboardToController(keyboardToController),
        .mouseToController(mouseToController), .bankSelect(bankSelect),
        .powerButtonPulse(powerButtonPulse), .powerWakeupRequestN(powerWakeupRequestN),
        .systemMgmtInterruptN(systemMgmtInterruptN));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        address     <= a;
        writeData   <= v;
        writeStrobe <= 1'b1;
        @(posedge clk);
        writeStrobe <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        address    <= a;
        readStrobe <= 1'b1;
        @(posedge clk);
        readStrobe <= 1'b0;
        #1;
        v = readData;
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic countPulse(input int n, output int k);
        k = 0;
        repeat (n) begin
            waitc(1);
            if (powerButtonPulse === 1'b1) k++;
        end
    endtask

    task automatic resetValues;
        for (int a = 2; a <= 4; a++) begin
            rd(8'(a), d);
            `CHK(d, 8'h00)
        end
        wr(8'h04, 8'h02);
        rd(8'h13, d);
        `CHK(d, 8'h00)
    endtask

    task automatic regAccess;
        wr(8'h02, 8'ha5);
        wr(8'h03, 8'h3c);
        wr(8'h04, 8'h06);
        rd(8'h02, d);
        `CHK(d, 8'ha5)
        rd(8'h03, d);
        `CHK(d, 8'h3c)
        rd(8'h04, d);
        `CHK(d, 8'h06)
        wr(8'h13, 8'h5f);
        for (int b = 0; b < 4; b++) begin
            wr(8'h04, {6'h00, 2'(b)});
            `CHK(bankSelect, 2'(b))
            if (b != 2) wr(8'h13, 8'h00);
            rd(8'h13, d);
            `CHK(d, (b == 2) ? 8'h5f : 8'h00)
        end
        wr(8'h04, 8'h02);
        rd(8'h13, d);
        `CHK(d, 8'h5f)
        wr(8'h13, 8'h00);
        wr(8'h02, 8'h00);
        wr(8'h03, 8'h00);
    endtask

    task automatic wakeSmi;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            primaryEventStatus <= 8'h01 << i;
            wr(8'h13, (8'h01 << i) & 8'h5f);
            waitc(6);
            `CHK(systemMgmtInterruptN, (i == 7 || i == 5) ? 1'b1 : 1'b0)
            `CHK(powerWakeupRequestN, 1'b1)
            wr(8'h02, 8'h01 << i);
            waitc(6);
            `CHK(powerWakeupRequestN, 1'b0)
            wr(8'h02, 8'h00);
            wr(8'h13, 8'h00);
        end
        wr(8'h13, 8'h04);
        @(posedge clk);
        primaryEventStatus <= 8'h04;
        waitc(6);
        `CHK(systemMgmtInterruptN, 1'b0)
        @(posedge clk);
        primaryEventStatus <= 8'h00;
        waitc(6);
        `CHK(systemMgmtInterruptN, 1'b1)
        wr(8'h13, 8'h00);
    endtask

    task automatic gpEvents;
        wr(8'h03, 8'h10);
        @(posedge clk);
        generalPurposeEventInput <= 8'h18;
        repeat (3) @(posedge clk);
        generalPurposeEventInput <= 8'h00;
        waitc(6);
        `CHK(powerWakeupRequestN, 1'b0)
        rd(8'h01, d);
        `CHK(d, 8'h18)
        wr(8'h01, 8'h00);
        waitc(6);
        `CHK(powerWakeupRequestN, 1'b0)
        wr(8'h01, 8'h10);
        waitc(6);
        `CHK(powerWakeupRequestN, 1'b1)
        rd(8'h01, d);
        `CHK(d, 8'h08)
        wr(8'h01, 8'h08);
        wr(8'h03, 8'h00);
    endtask

    task automatic swapAndPulse;
        @(posedge clk);
        keyboardPins <= '{clockIn: 1'b1, dataIn: 1'b0};
        mousePins    <= '{clockIn: 1'b0, dataIn: 1'b1};
        inS3         <= 1'b1;
        wr(8'h04, 8'h02);
        waitc(6);
        `CHK(keyboardToController, 2'b10)
        `CHK(mouseToController, 2'b01)
        wr(8'h04, 8'h06);
        waitc(6);
        `CHK(keyboardToController, 2'b01)
        `CHK(mouseToController, 2'b10)
        @(posedge clk);
        powerButtonRequest <= 1'b1;
        countPulse(20, c);
        `CHK(c, 0)
        @(posedge clk);
        powerButtonRequest <= 1'b0;
        wr(8'h04, 8'h0a);
        waitc(4);
        @(posedge clk);
        powerButtonRequest <= 1'b1;
        countPulse(25, c);
        `CHK(c, wake_pkg::PULSE_CYCLES)
        @(posedge clk);
        powerButtonRequest <= 1'b0;
        inS3               <= 1'b0;
        waitc(4);
        @(posedge clk);
        powerButtonRequest <= 1'b1;
        countPulse(20, c);
        `CHK(c, 0)
        @(posedge clk);
        powerButtonRequest <= 1'b0;
    endtask

    task automatic softRst;
        wr(8'h13, 8'h5f);
        wr(8'h02, 8'hff);
        wr(8'h03, 8'hff);
        wr(8'h04, 8'h0b);
        @(posedge clk);
        softReset <= 1'b1;
        @(posedge clk);
        softReset <= 1'b0;
        resetValues();
    endtask

    task automatic closeOut;
        $display("comparisons %0d, mismatches %0d", nTests, nErrors);
        if (nErrors == 0 && nTests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        resetn = 1'b0;
        softReset = 1'b0;
        address = 8'h00;
        writeData = 8'h00;
        writeStrobe = 1'b0;
        readStrobe = 1'b0;
        primaryEventStatus = 8'h00;
        generalPurposeEventInput = 8'h00;
        inS3 = 1'b0;
        powerButtonRequest = 1'b0;
        keyboardPins = '0;
        mousePins = '0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        resetValues();
        regAccess();
        wakeSmi();
        gpEvents();
        swapAndPulse();
        softRst();
        closeOut();
    end

    initial begin
        #100000;
        nErrors++;
        closeOut();
    end
endmodule
